// ---- rtl/mac_mode_control.sv ----
// two-wire slave with result registers and converter mode control register
`timescale 1ns/100ps
`default_nettype none
module mac_mode_control
	import mac_pkg::*;
#(
	parameter logic [6:0] DEVICE_ADDR = mac_pkg::DEVICE_ADDR_DEFAULT,
	parameter int         HANG_CYCLES = mac_pkg::HANG_CYCLES_DEFAULT
) (
	// clock and reset
	input  wire logic                   REF_CLK,
	input  wire logic                   RST_N,
	// serial bus
	input  wire logic                   SCL_IN,
	input  wire logic                   SDA_IN,
	output logic                        SDA_OUT,
	output logic                        SDA_OE,
	// converter
	output mac_pkg::mac_conv_req_s      CONV_REQ,
	input  wire mac_pkg::mac_conv_res_s CONV_RES,
	// busy view
	output logic [2:0]                  BUSY
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD,
		ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
	} mac_bus_state_e;

	// ****************************************************************
	// pin synchronisers and condition detect
	// ****************************************************************
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_prev;
	logic       sda_prev;
	wire        scl = scl_sync[1];
	wire        sda = sda_sync[1];
	wire        scl_rise = scl && !scl_prev;
	wire        scl_fall = !scl && scl_prev;
	wire        start_cond = scl && scl_prev && sda_prev && !sda;
	wire        stop_cond = scl && scl_prev && !sda_prev && sda;

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], SCL_IN};
			sda_sync <= {sda_sync[0], SDA_IN};
			scl_prev <= scl;
			sda_prev <= sda;
		end
	end

	// ****************************************************************
	// register bank
	// ****************************************************************
	logic [7:0]  control;
	logic [11:0] result [NUM_CHANNELS];
	logic [2:0]  ptr;
	logic [7:0]  shift;
	logic        wr_strobe;
	logic        upd_valid;
	logic [1:0]  upd_channel;
	logic [2:0]  busy;

	wire         test_mode = control[TEST_ENABLE_BIT];
	wire         page_en = control[PAGE_ENABLE_BIT];
	wire         hang_en = control[HANG_ENABLE_BIT];
	wire  [1:0]  wr_chan = ptr[2:1];
	wire  [7:0]  next_control = shift & CONTROL_WRITE_MASK;
	wire         ctrl_write = wr_strobe && ptr == ADDR_CONTROL;
	wire         res_write = wr_strobe && ptr < ADDR_CONTROL
		&& test_mode;
	wire         snap_request = ctrl_write
		&& next_control[SNAPSHOT_ENABLE_BIT];
	// a snapshot write flags the channel it names, not the old one
	wire  [1:0]  sel_now = ctrl_write
		? next_control[SEL_HI_BIT:SEL_LO_BIT]
		: control[SEL_HI_BIT:SEL_LO_BIT];
	wire  [1:0]  rd_chan = ptr[2:1];
	wire  [7:0]  rd_hi = result[rd_chan][11:4];
	wire  [7:0]  rd_lo = {result[rd_chan][3:0], busy[rd_chan],
		3'h0};
	wire  [7:0]  rd_byte = (ptr == ADDR_CONTROL) ? control
		: (ptr == ADDR_RESERVED) ? 8'h00
		: ptr[0] ? rd_lo : rd_hi;

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			control <= CONTROL_RESET;
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				result[i] <= 12'h000;
			end
		end else begin
			if (ctrl_write) begin
				control <= next_control;
			end
			if (upd_valid && !test_mode) begin
				result[upd_channel] <= CONV_RES.data;
			end
			if (res_write) begin
				if (ptr[0]) begin
					result[wr_chan][3:0] <= shift[7:4];
				end else begin
					result[wr_chan][11:4] <= shift;
				end
			end
		end
	end

	mac_sequencer u_seq (
		.ref_clk                  (REF_CLK),
		.rst_n                    (RST_N),
		.snapshot_enable          (control[SNAPSHOT_ENABLE_BIT]),
		.snapshot_channel_sel     (sel_now),
		.result_write_test_enable (test_mode),
		.snap_request             (snap_request),
		.conv_req                 (CONV_REQ),
		.conv_res                 (CONV_RES),
		.upd_valid                (upd_valid),
		.upd_channel              (upd_channel),
		.busy                     (busy)
	);

	// ****************************************************************
	// bus-hang timer
	// ****************************************************************
	logic [31:0] hang_count;
	mac_bus_state_e state;
	wire hang_reset = hang_en && hang_count == 32'(HANG_CYCLES);

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			hang_count <= 32'h0;
		end else if (!hang_en || scl || state == ST_IDLE || hang_reset) begin
			hang_count <= 32'h0;
		end else begin
			hang_count <= hang_count + 32'h1;
		end
	end

	// ****************************************************************
	// serial slave
	// ****************************************************************
	logic [2:0] bit_count;
	logic       got_byte;
	logic       rw;
	logic       wrote;
	logic       host_ack;
	logic [7:0] tx;
	wire        receiving = state == ST_ADDR || state == ST_CMD
		|| state == ST_WR;
	wire        can_write = page_en || !wrote;

	assign wr_strobe = scl_fall && state == ST_WR && got_byte && can_write;

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			state     <= ST_IDLE;
			ptr       <= 3'h0;
			shift     <= 8'h00;
			bit_count <= 3'h0;
			got_byte  <= 1'b0;
			rw        <= 1'b0;
			wrote     <= 1'b0;
			host_ack  <= 1'b0;
			tx        <= 8'h00;
			SDA_OUT   <= 1'b0;
			SDA_OE    <= 1'b0;
			BUSY      <= 3'h0;
		end else begin
			BUSY <= busy;
			if (stop_cond || hang_reset) begin
				state  <= ST_IDLE;
				ptr    <= 3'h0;
				SDA_OE <= 1'b0;
			end else if (start_cond) begin
				state     <= ST_ADDR;
				bit_count <= 3'h0;
				got_byte  <= 1'b0;
				SDA_OE    <= 1'b0;
			end else if (scl_rise) begin
				if (receiving) begin
					shift     <= {shift[6:0], sda};
					bit_count <= bit_count + 3'h1;
					got_byte  <= bit_count == 3'h7;
				end else if (state == ST_RD) begin
					bit_count <= bit_count + 3'h1;
					got_byte  <= bit_count == 3'h7;
				end else if (state == ST_ACK_RD) begin
					host_ack <= !sda;
					if (!sda && page_en) begin
						ptr <= ptr + 3'h1;
					end
				end
			end else if (scl_fall) begin
				case (state)
					ST_ADDR: if (got_byte) begin
						got_byte <= 1'b0;
						if (shift[7:1] == DEVICE_ADDR) begin
							rw     <= shift[0];
							SDA_OE <= 1'b1;
							state  <= ST_ACK_ADDR;
						end else begin
							state <= ST_IDLE;
						end
					end
					ST_ACK_ADDR: begin
						if (rw) begin
							tx        <= rd_byte;
							SDA_OE    <= !rd_byte[7];
							bit_count <= 3'h0;
							state     <= ST_RD;
						end else begin
							SDA_OE <= 1'b0;
							state  <= ST_CMD;
						end
					end
					ST_CMD: if (got_byte) begin
						got_byte <= 1'b0;
						ptr      <= shift[2:0];
						SDA_OE   <= 1'b1;
						state    <= ST_ACK_CMD;
					end
					ST_ACK_CMD: begin
						SDA_OE <= 1'b0;
						wrote  <= 1'b0;
						state  <= ST_WR;
					end
					ST_WR: if (got_byte) begin
						got_byte <= 1'b0;
						SDA_OE   <= can_write;
						state    <= ST_ACK_WR;
					end
					ST_ACK_WR: begin
						SDA_OE <= 1'b0;
						if (page_en) begin
							ptr <= ptr + 3'h1;
						end
						wrote <= 1'b1;
						state <= ST_WR;
					end
					ST_RD: begin
						if (got_byte) begin
							got_byte <= 1'b0;
							SDA_OE   <= 1'b0;
							state    <= ST_ACK_RD;
						end else begin
							tx     <= {tx[6:0], 1'b0};
							SDA_OE <= !tx[6];
						end
					end
					ST_ACK_RD: begin
						if (host_ack) begin
							tx        <= rd_byte;
							SDA_OE    <= !rd_byte[7];
							bit_count <= 3'h0;
							state     <= ST_RD;
						end else begin
							state <= ST_IDLE;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- rtl/mac_pkg.sv ----
// constants, types and register map of the monitor converter mode control
//
// Summary of operation
// - snapshot enable set converts only the channel named by the select bits.
// - after a snapshot conversion the busy flag clears and the converter halts.
// - snapshot enable clear (reset) makes the converter scan all channels.
// - test mode bit halts conversions and opens result registers to writes.
// - page access bit (reset one) allows auto-increment multi-byte transfers.
// - bus-hang timer bit (reset one) arms the stuck-bus interface reset.
// - the two low control bits read zero and ignore writes.
// - with the page access bit set, each host-acknowledged read byte advances the pointer to the next register.
// - a Stop condition returns the register pointer to address zero.
// - the command byte loads only its low three bits into the pointer.
// - each low result byte shows a read-only busy flag in bit 3.
// - result registers 0 to 5 take host writes only in test mode.
`default_nettype none
package mac_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [2:0] ADDR_SHUNT_HI   = 3'h0;
	localparam logic [2:0] ADDR_SUPPLY_HI  = 3'h2;
	localparam logic [2:0] ADDR_AUX_HI     = 3'h4;
	localparam logic [2:0] ADDR_CONTROL    = 3'h6;
	localparam logic [2:0] ADDR_RESERVED   = 3'h7;

	// ****************************************************************
	// control register fields
	// ****************************************************************
	localparam int SNAPSHOT_ENABLE_BIT    = 7;
	localparam int SEL_HI_BIT             = 6;
	localparam int SEL_LO_BIT             = 5;
	localparam int TEST_ENABLE_BIT        = 4;
	localparam int PAGE_ENABLE_BIT        = 3;
	localparam int HANG_ENABLE_BIT        = 2;
	localparam logic [7:0] CONTROL_WRITE_MASK = 8'hfc;
	localparam logic [7:0] CONTROL_RESET      = 8'h0c;
	localparam int BUSY_BIT               = 3;

	// ****************************************************************
	// channel codes
	// ****************************************************************
	localparam logic [1:0] CH_SHUNT  = 2'h0;
	localparam logic [1:0] CH_SUPPLY = 2'h1;
	localparam logic [1:0] CH_AUX    = 2'h2;
	localparam int NUM_CHANNELS      = 3;

	// ****************************************************************
	// bus and timing
	// ****************************************************************
	localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h67;
	localparam int CLK_MHZ                     = 40;
	localparam int HANG_TIME_US                = 30000;
	localparam int HANG_CYCLES_DEFAULT         = HANG_TIME_US * CLK_MHZ;

	typedef struct packed {
		logic       start;
		logic [1:0] channel;
	} mac_conv_req_s;

	typedef struct packed {
		logic        done;
		logic [11:0] data;
	} mac_conv_res_s;

endpackage
`default_nettype wire

// ---- rtl/mac_sequencer.sv ----
// converter sequencer: free-running scan, snapshot and test-mode halt
`timescale 1ns/100ps
`default_nettype none
module mac_sequencer
	import mac_pkg::*;
(
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst_n,
	// mode control
	input  wire logic                     snapshot_enable,
	input  wire logic [1:0]               snapshot_channel_sel,
	input  wire logic                     result_write_test_enable,
	input  wire logic                     snap_request,
	// converter
	output mac_pkg::mac_conv_req_s        conv_req,
	input  wire mac_pkg::mac_conv_res_s   conv_res,
	// result update
	output logic                          upd_valid,
	output logic [1:0]                    upd_channel,
	output logic [NUM_CHANNELS-1:0]       busy
);
	typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT} mac_seq_state_e;

	mac_seq_state_e state;
	logic           snap_pending;
	logic [1:0]     scan_channel;
	logic [1:0]     snap_channel;
	logic [1:0]     next_scan;

	// unused code 3 falls back to the shunt channel
	assign snap_channel = (snapshot_channel_sel == 2'h3) ? CH_SHUNT
		: snapshot_channel_sel;
	assign next_scan = (conv_req.channel == CH_AUX) ? CH_SHUNT
		: conv_req.channel + 2'h1;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state        <= SQ_IDLE;
			snap_pending <= 1'b0;
			scan_channel <= CH_SHUNT;
			conv_req     <= '0;
			upd_valid    <= 1'b0;
			upd_channel  <= CH_SHUNT;
			busy         <= '0;
		end else begin
			conv_req.start <= 1'b0;
			upd_valid      <= 1'b0;
			if (snap_request) begin
				snap_pending       <= 1'b1;
				busy[snap_channel] <= 1'b1;
			end
			case (state)
				SQ_IDLE: begin
					if (result_write_test_enable) begin
						state <= SQ_IDLE;
					end else if (snapshot_enable) begin
						if (snap_pending && !snap_request) begin
							conv_req.start   <= 1'b1;
							conv_req.channel <= snap_channel;
							snap_pending     <= 1'b0;
							state            <= SQ_WAIT;
						end
					end else begin
						conv_req.start   <= 1'b1;
						conv_req.channel <= scan_channel;
						state            <= SQ_WAIT;
					end
				end
				SQ_WAIT: begin
					if (conv_res.done) begin
						upd_valid   <= 1'b1;
						upd_channel <= conv_req.channel;
						// a scan result must not clear a snapshot still waiting
						if (!((snap_request || snap_pending)
								&& snap_channel == conv_req.channel)) begin
							busy[conv_req.channel] <= 1'b0;
						end
						scan_channel <= next_scan;
						state        <= SQ_IDLE;
					end
				end
				default: state <= SQ_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- testbench/mac_checker.sv ----
// port assertions for the mode control block
`timescale 1ns/100ps
`default_nettype none
module mac_checker
	import mac_pkg::*;
(
	// clock and reset
	input  wire logic                   REF_CLK,
	input  wire logic                   RST_N,
	// serial bus
	input  wire logic                   SCL_IN,
	input  wire logic                   SDA_IN,
	input  wire logic                   SDA_OUT,
	input  wire logic                   SDA_OE,
	// converter and busy view
	input  wire mac_pkg::mac_conv_req_s CONV_REQ,
	input  wire mac_pkg::mac_conv_res_s CONV_RES,
	input  wire logic [2:0]             BUSY
);
	logic outst;
	logic snap;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	// ****************************************************************
	// outstanding conversion tracking
	// ****************************************************************
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			outst <= 1'b0;
			snap  <= 1'b0;
		end else if (CONV_REQ.start) begin
			outst <= 1'b1;
			snap  <= |BUSY;
		end else if (CONV_RES.done) begin
			outst <= 1'b0;
			snap  <= 1'b0;
		end
	end
	// ****************************************************************
	// properties
	// ****************************************************************
	sequence s_snap_set;
		$rose(|BUSY);
	endsequence
	sequence s_snap_go;
		CONV_REQ.start && BUSY[CONV_REQ.channel];
	endsequence
	property p_open_drain;
		SDA_OUT == 1'b0;
	endproperty
	property p_oe_scl_low;
		$changed(SDA_OE) |-> !SCL_IN;
	endproperty
	property p_start_pulse;
		CONV_REQ.start |=> !CONV_REQ.start;
	endproperty
	property p_one_out;
		CONV_REQ.start |-> !outst;
	endproperty
	property p_reset_quiet;
		disable iff (1'b0) !RST_N [*2] |=> (!SDA_OE && BUSY == 3'h0);
	endproperty
	property p_first_scan;
		$rose(RST_N) |-> ##[0:2] CONV_REQ.start;
	endproperty
	property p_snap_go;
		s_snap_set |-> ##[0:8] s_snap_go;
	endproperty
	property p_busy_clr;
		CONV_RES.done && snap |-> ##[1:3] (BUSY == 3'h0);
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("sda driven high");
	a_oe_scl_low: assert property (p_oe_scl_low)
		else $error("sda moved, scl high");
	a_start_pulse: assert property (p_start_pulse)
		else $error("long start");
	a_one_out: assert property (p_one_out)
		else $error("second request");
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("reset not quiet");
	a_first_scan: assert property (p_first_scan)
		else $error("no scan");
	a_snap_go: assert property (p_snap_go)
		else $error("no snapshot");
	a_busy_clr: assert property (p_busy_clr)
		else $error("busy stuck");
endmodule
bind mac_mode_control mac_checker u_mac_checker (.REF_CLK(REF_CLK),
	.RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
	.SDA_OE(SDA_OE), .CONV_REQ(CONV_REQ), .CONV_RES(CONV_RES), .BUSY(BUSY));
`default_nettype wire

// ---- testbench/mac_host.sv ----
// two-wire bus host model
`timescale 1ns/100ps
`default_nettype none
module mac_host (
	// clock and line
	input  wire logic ref_clk,
	input  wire logic sda,
	// driven pins, released high
	output var logic  scl = 1'b1,
	output var logic  sda_rel = 1'b1
);
	task automatic half();
		repeat (10) @(posedge ref_clk);
		#1;
	endtask
	task automatic clk_bit(input logic b);
		sda_rel = b;
		half();
		scl = 1'b1;
		half();
		scl = 1'b0;
	endtask
	task automatic start();
		sda_rel = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_rel = 1'b0;
		half();
		scl = 1'b0;
	endtask
	// stop also returns the device pointer to zero
	task automatic stop();
		sda_rel = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_rel = 1'b1;
		half();
	endtask
	task automatic wb(input logic [7:0] v, output logic ack);
		for (int i = 7; i >= 0; i--) clk_bit(v[i]);
		sda_rel = 1'b1;
		half();
		scl = 1'b1;
		half();
		ack = !sda;
		scl = 1'b0;
	endtask
	task automatic rb(output logic [7:0] v, input logic more);
		for (int i = 7; i >= 0; i--) begin
			sda_rel = 1'b1;
			half();
			scl = 1'b1;
			half();
			v[i] = sda;
			scl = 1'b0;
		end
		clk_bit(!more);
	endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the mode control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import mac_pkg::*;
	localparam logic [6:0] DA = 7'h67;
	logic          ref_clk = 1'b0;
	logic          rst_n = 1'b0;
	logic          ack;
	wire logic     scl, sda_rel, sda_oe, sda_out, sda;
	wire logic [2:0] busy;
	mac_conv_req_s req;
	mac_conv_res_s res = '0;
	logic [1:0]    cch = 2'h0;
	logic [7:0]    rd [8];
	int            cd = 0, n_st = 0, n0, fails = 0, n_compared = 0;
	always #12.5 ref_clk = ~ref_clk;
	assign sda = sda_rel & !sda_oe;
	mac_mode_control #(.DEVICE_ADDR(DA), .HANG_CYCLES(200)) u_mac_mode_control (
		.REF_CLK(ref_clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .CONV_REQ(req), .CONV_RES(res),
		.BUSY(busy));
	mac_host u_mac_host (.ref_clk(ref_clk), .sda(sda), .scl(scl),
		.sda_rel(sda_rel));
	function automatic logic [11:0] dat(input logic [1:0] c);
		return {c, 10'h2c5};
	endfunction
	// converter answers each start five cycles later
	always @(posedge ref_clk) begin
		#1;
		res = (cd == 1) ? {1'b1, dat(cch)} : {1'b0, res.data};
		if (cd > 0) cd--;
		if (req.start) begin
			cd = 5;
			cch = req.channel;
			n_st++;
		end
	end
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wreg(input logic [2:0] a, input logic [7:0] v);
		u_mac_host.start();
		u_mac_host.wb({DA, 1'b0}, ack);
		chk("address ack", {7'h0, ack}, 8'h01);
		u_mac_host.wb({5'h0, a}, ack);
		u_mac_host.wb(v, ack);
		u_mac_host.stop();
	endtask
	// read n bytes, optionally without a command byte first
	task automatic rseq(input logic skip, input logic [7:0] cmd, input int n);
		if (!skip) begin
			u_mac_host.start();
			u_mac_host.wb({DA, 1'b0}, ack);
			u_mac_host.wb(cmd, ack);
		end
		u_mac_host.start();
		u_mac_host.wb({DA, 1'b1}, ack);
		for (int i = 0; i < n; i++) u_mac_host.rb(rd[i], i < n - 1);
		u_mac_host.stop();
	endtask
	task automatic t_defaults();
		rseq(1'b0, 8'h06, 1);
		chk("control reset", rd[0], CONTROL_RESET);
		wreg(ADDR_CONTROL, 8'h0b);
		rseq(1'b0, 8'h06, 1);
		chk("control low bits", rd[0], 8'h08);
		wreg(ADDR_CONTROL, 8'h0c);
		$display("test defaults done");
	endtask
	task automatic t_page();
		rseq(1'b0, 8'h00, 8);
		for (int c = 0; c < 3; c++) begin
			chk("high byte", rd[2*c], 8'(dat(c[1:0]) >> 4));
			chk("low byte", rd[2*c+1], 8'h50);
		end
		chk("control in page", rd[6], 8'h0c);
		chk("reserved", rd[7], 8'h00);
		rseq(1'b1, 8'h00, 1);
		chk("pointer after stop", rd[0], 8'(dat(2'h0) >> 4));
		rseq(1'b0, 8'hfa, 1);
		chk("command low bits", rd[0], 8'(dat(2'h1) >> 4));
		$display("test page done");
	endtask
	// leave a write hanging with scl low, then read without a command
	task automatic t_hang();
		logic [11:0] ev;
		for (int h = 1; h >= 0; h--) begin
			wreg(ADDR_CONTROL, h ? 8'h0c : 8'h08);
			u_mac_host.start();
			u_mac_host.wb({DA, 1'b0}, ack);
			u_mac_host.wb({5'h0, ADDR_AUX_HI}, ack);
			repeat (300) @(posedge ref_clk);
			#1;
			rseq(1'b1, 8'h00, 1);
			ev = h ? dat(2'h0) : dat(2'h2);
			chk("hang pointer", rd[0], 8'(ev >> 4));
		end
		wreg(ADDR_CONTROL, 8'h0c);
		$display("test hang done");
	endtask
	task automatic t_test();
		wreg(ADDR_CONTROL, 8'h1c);
		repeat (20) @(posedge ref_clk);
		n0 = n_st;
		wreg(ADDR_SUPPLY_HI, 8'h77);
		wreg(ADDR_CONTROL, 8'h14);
		rseq(1'b0, 8'h02, 2);
		chk("test write", rd[0], 8'h77);
		chk("page off", rd[1], 8'h77);
		chk("halted", 8'(n_st - n0), 8'h00);
		$display("test mode done");
	endtask
	task automatic t_snap();
		for (int c = 1; c < 3; c++) begin
			n0 = n_st;
			wreg(ADDR_CONTROL, {1'b1, c[1:0], 5'h0c});
			repeat (50) @(posedge ref_clk);
			chk("one conversion", 8'(n_st - n0), 8'h01);
			chk("channel", {6'h0, cch}, 8'(c));
			rseq(1'b0, 8'(2 * c + 1), 1);
			chk("busy cleared", rd[0], 8'h50);
		end
		wreg(ADDR_AUX_HI, 8'h11);
		rseq(1'b0, 8'h04, 1);
		chk("write outside test", rd[0], 8'(dat(2'h2) >> 4));
		n0 = n_st;
		wreg(ADDR_CONTROL, 8'h0c);
		repeat (40) @(posedge ref_clk);
		chk("scan resumes", 8'(n_st - n0 > 3), 8'h01);
		$display("test snapshot done");
	endtask
	task automatic conclude();
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		repeat (5) @(posedge ref_clk);
		t_defaults();
		t_page();
		t_hang();
		t_test();
		t_snap();
		conclude();
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		fails++;
		conclude();
	end
endmodule
`default_nettype wire
